/* File: fsp_map.vh */
// field positions, command codes and timing constants of the flash status block
`ifndef FSP_MAP_VH
`define FSP_MAP_VH
// status byte one
`define FSP_B1_BUSY      0
`define FSP_B1_LATCH     1
`define FSP_B1_GUARD_LO  2
`define FSP_B1_GUARD_HI  6
`define FSP_B1_LOCK_LO   7
// status byte two
`define FSP_B2_ADDR_W    0
`define FSP_B2_FOUR_LANE 1
`define FSP_B2_PROG_HOLD 2
`define FSP_B2_OTP_LO    3
`define FSP_B2_OTP_HI    5
`define FSP_B2_LOCK_HI   6
`define FSP_B2_ERASE_HLD 7
// status byte three
`define FSP_B3_LAT_LO    0
`define FSP_B3_LAT_HI    1
`define FSP_B3_PROG_FAIL 2
`define FSP_B3_CLR_FAIL  3
`define FSP_B3_BOOT_AW   4
`define FSP_B3_DRV_LO    5
`define FSP_B3_DRV_HI    6
// reset values of the drive and latency fields
`define FSP_DRV_RST      2'h1
`define FSP_LAT_RST      2'h0
// command codes
`define FSP_CMD_LATCH_SET  8'h06
`define FSP_CMD_LATCH_DROP 8'h04
`define FSP_CMD_RD1        8'h05
`define FSP_CMD_RD2        8'h35
`define FSP_CMD_RD3        8'h15
`define FSP_CMD_WR1        8'h01
`define FSP_CMD_WR2        8'h31
`define FSP_CMD_WR3        8'h11
`define FSP_CMD_PAGE       8'h02
`define FSP_CMD_PAGE4      8'h12
`define FSP_CMD_SMALL      8'h20
`define FSP_CMD_SMALL4     8'h21
`define FSP_CMD_BLOCK32    8'h52
`define FSP_CMD_BLOCK      8'hd8
`define FSP_CMD_FULL       8'hc7
`define FSP_CMD_FULL_ALT   8'h60
`define FSP_CMD_SUSPEND    8'h75
`define FSP_CMD_RESUME     8'h7a
`define FSP_CMD_RST_EN     8'h66
`define FSP_CMD_RST        8'h99
`define FSP_CMD_SLEEP      8'hb9
`define FSP_CMD_WAKE       8'hab
`define FSP_CMD_ENTER4     8'hb7
`define FSP_CMD_EXIT4      8'he9
// array geometry
`define FSP_ADDR_W       25
`define FSP_BLK_SHIFT    16
`define FSP_CODE_MAX     4'h9
// busy times in cycles
`define FSP_T_CFG_WR     16'h0010
`define FSP_T_PROG       16'h0040
`define FSP_T_ERASE      16'h0100
`endif

/* File: fsp_guard_decode.v */
// region guard decoder: is an address inside the guarded region
`timescale 1ns/1ns
`include "fsp_map.vh"
module fsp_guard_decode #(
   parameter AW = `FSP_ADDR_W
)(
   input  wire [4:0]    guard_i,
   input  wire [AW-1:0] addr_i,
   input  wire          whole_i,
   output reg           hit_o
);
   reg [8:0] blk;
   reg [8:0] span;
   reg [3:0] code;
   always @*
   begin
      blk  = addr_i[AW-1:`FSP_BLK_SHIFT];
      code = guard_i[3:0];
      span = 9'h000;
      hit_o = 1'b0;
      if (guard_i[3] && (guard_i[2] || guard_i[1]))
         hit_o = 1'b1;
      else if (whole_i)
         hit_o = (code != 4'h0);
      else if (code != 4'h0 && code <= `FSP_CODE_MAX)
      begin
         span = (9'h001 << (code - 4'h1)) - 9'h001;
         if (guard_i[4])
            hit_o = (blk <= span);
         else
            hit_o = (blk >= (9'h1ff - span));
      end
   end
endmodule

/* File: fsp_busy_timer.v */
// busy timer: holds busy while a program, erase or status write runs
`timescale 1ns/1ns
module fsp_busy_timer #(
   parameter CW = 16
)(
   input  wire          mclk_i,
   input  wire          nrst_i,
   input  wire          start_i,
   input  wire [CW-1:0] len_i,
   input  wire          hold_i,
   input  wire          abort_i,
   output wire          busy_o,
   output wire          done_o
);
   reg [CW-1:0] cnt;
   assign busy_o = (cnt != {CW{1'b0}});
   assign done_o = (cnt == {{(CW-1){1'b0}}, 1'b1}) && !hold_i && !abort_i;
   always @(posedge mclk_i)
   begin
      if (!nrst_i || abort_i)
         cnt <= {CW{1'b0}};
      else if (start_i)
         cnt <= len_i;
      else if (busy_o && !hold_i)
         cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
   end
endmodule

/* File: fsp_status_core.v */
// status, latch and protection core of a serial flash, fed by decoded commands
`timescale 1ns/1ns
`include "fsp_map.vh"
// What this block does
// - latch_set_cmd sets write_latch_flag.
// - power-up, reset pair, drop, status write, program, erases clear the latch.
// - in deep power-down only wake and the reset pair are obeyed.
// - guard bit4=0, code n: top 64KB*2^(n-1) from block 511 protected.
// - guard bit4=1, code n: bottom 64KB*2^(n-1) from block 0 protected.
// - program and erase into the guarded region are rejected; reads allowed.
// - byte one: lock_lo, guard[4:0], latch, busy.
// - byte two: erase hold, lock_hi, otp[3:1], prog hold, four lane, addr width.
// - byte three: reserved, drive, boot width, clear fail, prog fail, latency.
// - busy_flag high during program, erase or status write.
// - with latch clear, status write, program and erase are refused.
// - with both locks 0, status writes need latch set first.
// - lock (1,0) blocks status writes until power cycle, then clears.
// - both locks 1 block status writes forever.
// - addr_width_flag reports 0 for three-byte, 1 for four-byte addressing.
// - four_lane_on always reads 1, writes ignored.
// - suspend sets hold flags; resume, reset, power cycle clear them.
// - failed or guarded program/erase sets its fail flag; resume clears it.
module fsp_status_core #(
   parameter AW = `FSP_ADDR_W,
   parameter CW = 16
)(
   input  wire          mclk_i,
   input  wire          nrst_i,
   input  wire          por_i,
   input  wire          cmd_vld_i,
   input  wire [7:0]    cmd_i,
   input  wire [AW-1:0] addr_i,
   input  wire [7:0]    wdata_i,
   input  wire          op_fail_i,
   output reg  [7:0]    rdata_o,
   output reg           rvld_o,
   output reg           rejected_o,
   output reg           busy_o,
   output reg           sleep_o,
   output reg           four_byte_o,
   output reg  [1:0]    drive_o,
   output reg  [1:0]    latency_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg       write_latch_flag;
   reg [4:0] region_guard_bits;
   reg       guard_lock_lo;
   reg       guard_lock_hi;
   reg [2:0] otp_lock_bits;
   reg       erase_hold_flag;
   reg       prog_hold_flag;
   reg       addr_width_flag;
   reg       boot_addr_width;
   reg       clear_fail_flag;
   reg       prog_fail_flag;
   reg [1:0] drive_level;
   reg [1:0] latency_cfg;
   reg       rst_armed;
   reg       sleeping;
   reg       op_is_erase;
   reg       boot_load;

   wire       busy_flag;
   wire       op_done;
   wire       guard_hit;
   wire       four_lane_on = 1'b1;
   wire [7:0] byte_one;
   wire [7:0] byte_two;
   wire [7:0] byte_three;

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire is_prog  = (cmd_i == `FSP_CMD_PAGE) || (cmd_i == `FSP_CMD_PAGE4);
   wire is_full  = (cmd_i == `FSP_CMD_FULL) || (cmd_i == `FSP_CMD_FULL_ALT);
   wire is_erase = (cmd_i == `FSP_CMD_SMALL) || (cmd_i == `FSP_CMD_SMALL4) ||
                   (cmd_i == `FSP_CMD_BLOCK32) || (cmd_i == `FSP_CMD_BLOCK) || is_full;
   wire is_cfg_wr = (cmd_i == `FSP_CMD_WR1) || (cmd_i == `FSP_CMD_WR2) ||
                    (cmd_i == `FSP_CMD_WR3);
   wire is_read  = (cmd_i == `FSP_CMD_RD1) || (cmd_i == `FSP_CMD_RD2) ||
                   (cmd_i == `FSP_CMD_RD3);
   wire is_rst   = rst_armed && (cmd_i == `FSP_CMD_RST);

   // ---------------------------------------------------------------
   // request gating
   // ---------------------------------------------------------------
   // sleep filter
   wire live     = cmd_vld_i && (!sleeping || cmd_i == `FSP_CMD_WAKE ||
                   cmd_i == `FSP_CMD_RST_EN || is_rst);
   wire idle     = !busy_flag;
   wire sr_locked = guard_lock_hi;
   wire cfg_wr_ok = live && idle && is_cfg_wr && write_latch_flag && !sr_locked;
   wire op_req   = live && idle && (is_prog || is_erase) && write_latch_flag &&
                   !prog_hold_flag && !erase_hold_flag;
   wire op_ok    = op_req && !guard_hit;
   wire op_bad   = op_req && guard_hit;
   wire suspend  = live && (cmd_i == `FSP_CMD_SUSPEND) && busy_flag;
   wire resume   = live && (cmd_i == `FSP_CMD_RESUME) && (prog_hold_flag || erase_hold_flag);
   wire prog_fail_set = (op_bad && is_prog) || (op_done && op_fail_i && !op_is_erase);
   wire clr_fail_set  = (op_bad && is_erase) || (op_done && op_fail_i && op_is_erase);
   wire [CW-1:0] op_len = is_cfg_wr ? `FSP_T_CFG_WR :
                          (is_prog ? `FSP_T_PROG : `FSP_T_ERASE);

   // ---------------------------------------------------------------
   // region guard and busy timer
   // ---------------------------------------------------------------
   fsp_guard_decode #(
      .AW(AW)
   ) u_guard (
      .guard_i (region_guard_bits),
      .addr_i  (addr_i),
      .whole_i (is_full),
      .hit_o   (guard_hit)
   );

   fsp_busy_timer #(
      .CW(CW)
   ) u_busy (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .start_i (cfg_wr_ok || op_ok),
      .len_i   (op_len),
      .hold_i  (prog_hold_flag || erase_hold_flag),
      .abort_i (por_i || (live && is_rst)),
      .busy_o  (busy_flag),
      .done_o  (op_done)
   );

   // ---------------------------------------------------------------
   // status bytes
   // ---------------------------------------------------------------
   // byte one layout
   assign byte_one = {guard_lock_lo, region_guard_bits, write_latch_flag, busy_flag};
   assign byte_two = {erase_hold_flag, guard_lock_hi, otp_lock_bits, prog_hold_flag,
                      four_lane_on, addr_width_flag};
   assign byte_three = {1'b0, drive_level, boot_addr_width, clear_fail_flag, prog_fail_flag,
                        latency_cfg};

   // ---------------------------------------------------------------
   // non-volatile fields: kept over software reset and power-up; power-up clears the locks unless both are set
   // ---------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         region_guard_bits <= 5'h00;
         guard_lock_lo     <= 1'b0;
         guard_lock_hi     <= 1'b0;
         otp_lock_bits     <= 3'h0;
         boot_addr_width   <= 1'b0;
         drive_level       <= `FSP_DRV_RST;
         latency_cfg       <= `FSP_LAT_RST;
      end
      else if (por_i && !(guard_lock_hi && guard_lock_lo))
      begin
         guard_lock_hi <= 1'b0;
         guard_lock_lo <= 1'b0;
      end
      // guard bits only via status write
      else if (cfg_wr_ok)
      begin
         case (cmd_i)
            `FSP_CMD_WR1:
            begin
               guard_lock_lo     <= wdata_i[`FSP_B1_LOCK_LO];
               region_guard_bits <= wdata_i[`FSP_B1_GUARD_HI:`FSP_B1_GUARD_LO];
            end
            `FSP_CMD_WR2:
            begin
               guard_lock_hi <= wdata_i[`FSP_B2_LOCK_HI];
               otp_lock_bits <= otp_lock_bits | wdata_i[`FSP_B2_OTP_HI:`FSP_B2_OTP_LO];
            end
            default:
            begin
               drive_level     <= wdata_i[`FSP_B3_DRV_HI:`FSP_B3_DRV_LO];
               boot_addr_width <= wdata_i[`FSP_B3_BOOT_AW];
               latency_cfg     <= wdata_i[`FSP_B3_LAT_HI:`FSP_B3_LAT_LO];
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // volatile fields
   // ---------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         write_latch_flag <= 1'b0;
         erase_hold_flag  <= 1'b0;
         prog_hold_flag   <= 1'b0;
         addr_width_flag  <= 1'b0;
         clear_fail_flag  <= 1'b0;
         prog_fail_flag   <= 1'b0;
         rst_armed        <= 1'b0;
         sleeping         <= 1'b0;
         op_is_erase      <= 1'b0;
         boot_load        <= 1'b1;
      end
      else if (por_i || (live && is_rst))
      begin
         write_latch_flag <= 1'b0;
         erase_hold_flag  <= 1'b0;
         prog_hold_flag   <= 1'b0;
         rst_armed        <= 1'b0;
         sleeping         <= 1'b0;
         boot_load        <= 1'b1;
      end
      else
      begin
         boot_load <= 1'b0;
         if (boot_load)
            addr_width_flag <= boot_addr_width;
         else if (live && cmd_i == `FSP_CMD_ENTER4)
            addr_width_flag <= 1'b1;
         else if (live && cmd_i == `FSP_CMD_EXIT4)
            addr_width_flag <= 1'b0;
         if (live)
            rst_armed <= (cmd_i == `FSP_CMD_RST_EN);
         if (live && idle && cmd_i == `FSP_CMD_SLEEP)
            sleeping <= 1'b1;
         else if (live && cmd_i == `FSP_CMD_WAKE)
            sleeping <= 1'b0;
         if (live && idle && cmd_i == `FSP_CMD_LATCH_SET)
            write_latch_flag <= 1'b1;
         else if ((live && cmd_i == `FSP_CMD_LATCH_DROP) || cfg_wr_ok || op_req)
            write_latch_flag <= 1'b0;
         if (op_ok)
            op_is_erase <= is_erase;
         if (suspend)
         begin
            erase_hold_flag <= op_is_erase;
            prog_hold_flag  <= !op_is_erase;
         end
         else if (resume)
         begin
            erase_hold_flag <= 1'b0;
            prog_hold_flag  <= 1'b0;
         end
         if (prog_fail_set)
            prog_fail_flag <= 1'b1;
         else if (resume || (op_ok && is_prog))
            prog_fail_flag <= 1'b0;
         if (clr_fail_set)
            clear_fail_flag <= 1'b1;
         else if (resume || (op_ok && is_erase))
            clear_fail_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         rdata_o     <= 8'h00;
         rvld_o      <= 1'b0;
         rejected_o  <= 1'b0;
         busy_o      <= 1'b0;
         sleep_o     <= 1'b0;
         four_byte_o <= 1'b0;
         drive_o     <= `FSP_DRV_RST;
         latency_o   <= `FSP_LAT_RST;
      end
      else
      begin
         rvld_o     <= live && is_read;
         if (live && is_read)
         begin
            case (cmd_i)
               `FSP_CMD_RD2: rdata_o <= byte_two;
               `FSP_CMD_RD3: rdata_o <= byte_three;
               default:      rdata_o <= byte_one;
            endcase
         end
         rejected_o  <= (cmd_vld_i && !live) || op_bad ||
                        (live && (is_cfg_wr || is_prog || is_erase) && !cfg_wr_ok && !op_ok);
         busy_o      <= busy_flag;
         sleep_o     <= sleeping;
         four_byte_o <= addr_width_flag;
         drive_o     <= drive_level;
         latency_o   <= latency_cfg;
      end
   end
endmodule

/* File: fsp_status_core_asserts.sv */
// port assertions of the flash status core
`timescale 1ns/1ns
module fsp_status_core_asserts (
   input wire       mclk_i,
   input wire       nrst_i,
   input wire       cmd_vld_i,
   input wire [7:0] cmd_i,
   input wire [7:0] rdata_o,
   input wire       rvld_o,
   input wire       rejected_o,
   input wire       busy_o,
   input wire       sleep_o,
   input wire       four_byte_o
);
   reg [9:0] bcnt;
   reg       held;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // ----------
   // busy length, voided by suspend or reset
   // ----------
   always @(posedge mclk_i)
   begin
      bcnt <= (!nrst_i || !busy_o) ? 10'h000 : bcnt + 10'h001;
      if (!nrst_i || (cmd_vld_i && cmd_i == 8'h06 && !busy_o))
         held <= 1'b0;
      else if (cmd_vld_i && (cmd_i == 8'h75 || cmd_i == 8'h66))
         held <= 1'b1;
   end
   a_read_source: assert property (rvld_o |-> $past(cmd_vld_i) && $past(cmd_i) inside {8'h05, 8'h35, 8'h15})
      else $error("read answer without read command");
   a_latch_read: assert property (cmd_vld_i && cmd_i == 8'h06 && !sleep_o && !busy_o ##1 !cmd_vld_i
      ##1 !cmd_vld_i ##1 cmd_vld_i && cmd_i == 8'h05 |=> rdata_o[1])
      else $error("latch not set");
   a_drop_read: assert property (cmd_vld_i && cmd_i == 8'h04 && !sleep_o && !busy_o ##1 !cmd_vld_i
      ##1 !cmd_vld_i ##1 cmd_vld_i && cmd_i == 8'h05 |=> !rdata_o[1])
      else $error("latch not dropped");
   a_sleep_enter: assert property (cmd_vld_i && cmd_i == 8'hb9 && !sleep_o && !busy_o |-> ##2 sleep_o)
      else $error("sleep not entered");
   a_sleep_filter: assert property (sleep_o && cmd_vld_i && !(cmd_i inside {8'hab, 8'h66, 8'h99})
      |=> rejected_o && !rvld_o && sleep_o)
      else $error("command obeyed in sleep");
   a_sleep_wake: assert property (sleep_o && cmd_vld_i && cmd_i == 8'hab |-> ##2 !sleep_o)
      else $error("wake ignored");
   a_busy_len: assert property ($fell(busy_o) && !held |-> bcnt inside {10'h010, 10'h040, 10'h100})
      else $error("busy length wrong");
   a_lane_width: assert property (rvld_o && $past(cmd_i) == 8'h35 |-> rdata_o[1] && rdata_o[0] == $past(four_byte_o))
      else $error("byte two lane or width wrong");
   a_width_set: assert property (cmd_vld_i && cmd_i == 8'hb7 && !sleep_o && !busy_o |-> ##2 four_byte_o)
      else $error("four byte mode not set");
   c_read: cover property (rvld_o);
   c_busy_end: cover property ($fell(busy_o) && !held);
   c_sleep_refuse: cover property (rejected_o && sleep_o);
endmodule
bind fsp_status_core fsp_status_core_asserts chk_u (.mclk_i, .nrst_i, .cmd_vld_i, .cmd_i, .rdata_o, .rvld_o,
   .rejected_o, .busy_o, .sleep_o, .four_byte_o);

/* File: fsp_host_model.sv */
// host controller model issuing decoded commands
`timescale 1ns/1ns
module fsp_host_model (
   input  wire        mclk_i,
   input  wire        rvld_i,
   input  wire        rejected_i,
   input  wire [7:0]  rdata_i,
   output reg         cmd_vld_o,
   output reg  [7:0]  cmd_o,
   output reg  [24:0] addr_o,
   output reg  [7:0]  wdata_o
);
   reg       got_rv;
   reg       got_rej;
   reg [7:0] got_data;
   initial
   begin
      cmd_vld_o = 1'b0;
      cmd_o = 8'h00;
      addr_o = 25'h0000000;
      wdata_o = 8'h00;
   end
   // ----------
   // one command, answer collected
   // ----------
   task xfer(input [7:0] c, input [24:0] a, input [7:0] d);
      integer k;
      begin
         got_rv = 1'b0;
         got_rej = 1'b0;
         @(negedge mclk_i);
         cmd_vld_o = 1'b1;
         cmd_o = c;
         addr_o = a;
         wdata_o = d;
         for (k = 0; k < 2; k = k + 1)
         begin
            @(negedge mclk_i);
            if (k == 0)
            begin
               cmd_vld_o = 1'b0;
               cmd_o = ~c;
               addr_o = ~a;
               wdata_o = ~d;
            end
            if (rvld_i === 1'b1)
            begin
               got_rv = 1'b1;
               got_data = rdata_i;
            end
            if (rejected_i === 1'b1)
               got_rej = 1'b1;
         end
      end
   endtask
endmodule

/* File: fsp_status_core_test.sv */
// self-checking bench of the flash status core
`timescale 1ns/1ns
module fsp_status_core_test;
   reg         mclk_i;
   reg         nrst_i;
   reg         por_i;
   reg         op_fail_i;
   wire        cmd_vld_i, rvld_o, rejected_o, busy_o, sleep_o, four_byte_o;
   wire [7:0]  cmd_i, wdata_i, rdata_o;
   wire [24:0] addr_i;
   wire [1:0]  drive_o, latency_o;
   integer     fails;
   integer     checks_done;
   fsp_status_core dut_u (.mclk_i, .nrst_i, .por_i, .cmd_vld_i, .cmd_i, .addr_i, .wdata_i, .op_fail_i,
      .rdata_o, .rvld_o, .rejected_o, .busy_o, .sleep_o, .four_byte_o, .drive_o, .latency_o);
   fsp_host_model host_u (.mclk_i, .rvld_i(rvld_o), .rejected_i(rejected_o), .rdata_i(rdata_o),
      .cmd_vld_o(cmd_vld_i), .cmd_o(cmd_i), .addr_o(addr_i), .wdata_o(wdata_i));
   // ----------
   // helpers
   // ----------
   task chk(input [7:0] g, input [7:0] e, input string m);
      begin
         checks_done = checks_done + 1;
         if (g !== e)
         begin
            fails = fails + 1;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
         end
      end
   endtask
   task chk1(input f, input e, input string m);
      chk({7'h0, f}, {7'h0, e}, m);
   endtask
   task x(input [7:0] c);
      host_u.xfer(c, 25'h0, 8'h00);
   endtask
   task rd(input [7:0] c, input [7:0] e, input string m);
      begin
         x(c);
         chk1(host_u.got_rv, 1'b1, m);
         chk(host_u.got_data, e, m);
      end
   endtask
   task idle;
      integer k;
      begin
         k = 0;
         @(negedge mclk_i);
         while (busy_o !== 1'b0)
         begin
            k = k + 1;
            if (k > 600)
            begin
               fails = fails + 1;
               $display("MISMATCH %0t busy hang", $time);
               final_report;
            end
            @(negedge mclk_i);
         end
      end
   endtask
   task swr(input [7:0] c, input [7:0] d);
      begin
         x(8'h06);
         host_u.xfer(c, 25'h0, d);
         idle;
      end
   endtask
   task por;
      begin
         @(negedge mclk_i);
         por_i = 1'b1;
         @(negedge mclk_i);
         por_i = 1'b0;
      end
   endtask
   function prot(input [7:0] c, input [4:0] g, input [24:0] a);
      reg [25:0] sz;
      begin
         sz = 26'h0010000 << (g[3:0] - 4'h1);
         if (c == 8'hc7 || c == 8'h60 || (g[3] && (g[2] || g[1])))
            prot = g[3:0] != 4'h0;
         else if (g[3:0] == 4'h0)
            prot = 1'b0;
         else if (g[4])
            prot = {1'b0, a} < sz;
         else
            prot = {1'b0, a} >= 26'h2000000 - sz;
      end
   endfunction
   // ----------
   // scenarios
   // ----------
   task t_reset;
      begin
         rd(8'h05, 8'h00, "byte one");
         rd(8'h35, 8'h02, "byte two");
         rd(8'h15, 8'h20, "byte three");
         chk({6'h0, drive_o}, 8'h01, "drive");
         chk1(four_byte_o, 1'b0, "width");
         $display("reset done");
      end
   endtask
   task t_latch;
      begin
         x(8'h06);
         rd(8'h05, 8'h02, "latch set");
         x(8'h04);
         rd(8'h05, 8'h00, "latch drop");
         host_u.xfer(8'h01, 25'h0, 8'h04);
         chk1(host_u.got_rej, 1'b1, "write no latch");
         x(8'h02);
         chk1(host_u.got_rej, 1'b1, "prog no latch");
         rd(8'h05, 8'h00, "unchanged");
         x(8'h06);
         x(8'h66);
         x(8'h99);
         rd(8'h05, 8'h00, "reset pair");
         $display("latch done");
      end
   endtask
   task t_sleep;
      begin
         x(8'hb9);
         chk1(sleep_o, 1'b1, "sleep");
         x(8'h06);
         chk1(host_u.got_rej, 1'b1, "ignored");
         x(8'h05);
         chk1(host_u.got_rv, 1'b0, "no read");
         x(8'hab);
         chk1(sleep_o, 1'b0, "wake");
         rd(8'h05, 8'h00, "latch kept clear");
         x(8'hb9);
         x(8'h66);
         x(8'h99);
         chk1(sleep_o, 1'b0, "reset wakes");
         $display("sleep done");
      end
   endtask
   task t_addr;
      begin
         x(8'hb7);
         chk1(four_byte_o, 1'b1, "four byte");
         rd(8'h35, 8'h03, "width flag");
         x(8'he9);
         chk1(four_byte_o, 1'b0, "three byte");
         swr(8'h31, 8'h00);
         rd(8'h35, 8'h02, "lane fixed");
         swr(8'h11, 8'h5b);
         rd(8'h15, 8'h53, "byte three write");
         chk({6'h0, drive_o}, 8'h02, "drive out");
         chk({6'h0, latency_o}, 8'h03, "latency out");
         x(8'h66);
         x(8'h99);
         rd(8'h35, 8'h03, "boot width");
         swr(8'h11, 8'h20);
         x(8'he9);
         rd(8'h15, 8'h20, "byte three back");
         $display("addr done");
      end
   endtask
   task t_hold;
      begin
         x(8'h06);
         x(8'h02);
         chk1(busy_o, 1'b1, "busy");
         x(8'h75);
         rd(8'h35, 8'h06, "prog hold");
         x(8'h7a);
         rd(8'h35, 8'h02, "resumed");
         idle;
         x(8'h06);
         x(8'h20);
         x(8'h75);
         rd(8'h35, 8'h82, "erase hold");
         x(8'h66);
         x(8'h99);
         rd(8'h35, 8'h02, "reset clears");
         idle;
         $display("hold done");
      end
   endtask
   task t_guard;
      reg [37:0] e [0:10];
      integer    i;
      reg        p, pf, cf;
      begin
         e[0] = {8'h02, 5'h01, 25'h1ff0000};
         e[1] = {8'h12, 5'h01, 25'h1feffff};
         e[2] = {8'h52, 5'h09, 25'h1000000};
         e[3] = {8'hd8, 5'h09, 25'h0ff0000};
         e[4] = {8'h02, 5'h11, 25'h000ffff};
         e[5] = {8'h21, 5'h11, 25'h0010000};
         e[6] = {8'h02, 5'h0c, 25'h0000000};
         e[7] = {8'h02, 5'h1a, 25'h0800000};
         e[8] = {8'hc7, 5'h01, 25'h0000000};
         e[9] = {8'h02, 5'h00, 25'h1ffffff};
         e[10] = {8'h60, 5'h00, 25'h0000000};
         pf = 1'b0;
         cf = 1'b0;
         for (i = 0; i < 11; i = i + 1)
         begin
            swr(8'h01, {1'b0, e[i][29:25], 2'h0});
            p = prot(e[i][37:30], e[i][29:25], e[i][24:0]);
            x(8'h06);
            host_u.xfer(e[i][37:30], e[i][24:0], 8'h00);
            chk1(host_u.got_rej, p, "guarded");
            idle;
            if (e[i][37:30] == 8'h02 || e[i][37:30] == 8'h12)
               pf = p;
            else
               cf = p;
            rd(8'h15, {4'h2, cf, pf, 2'h0}, "fail flags");
            rd(8'h05, {1'b0, e[i][29:25], 2'h0}, "latch cleared");
         end
         op_fail_i = 1'b1;
         x(8'h06);
         x(8'h02);
         idle;
         op_fail_i = 1'b0;
         rd(8'h15, {4'h2, cf, 1'b1, 2'h0}, "prog failed");
         $display("guard done");
      end
   endtask
   task t_lock;
      begin
         swr(8'h31, 8'h40);
         rd(8'h35, 8'h42, "lock hi");
         swr(8'h01, 8'h04);
         chk1(host_u.got_rej, 1'b1, "supply lock");
         por;
         rd(8'h35, 8'h02, "lock cleared");
         swr(8'h01, 8'h80);
         swr(8'h31, 8'h40);
         swr(8'h01, 8'h04);
         chk1(host_u.got_rej, 1'b1, "lock forever");
         por;
         rd(8'h05, 8'h80, "byte one kept");
         rd(8'h35, 8'h42, "byte two kept");
         $display("lock done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d fails %0d", checks_done, fails);
         if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   initial
   begin
      fails = 0;
      checks_done = 0;
      nrst_i = 1'b0;
      por_i = 1'b0;
      op_fail_i = 1'b0;
      repeat (20) @(negedge mclk_i);
      nrst_i = 1'b1;
      t_reset;
      t_latch;
      t_sleep;
      t_addr;
      t_hold;
      t_guard;
      t_lock;
      final_report;
   end
endmodule
